/* src/pwm_pkg.sv */
// Package for the 14-bit PWM generator: register map, fields, reset values, carriers
package pwm_pkg;

    localparam int unsigned ADDR_W   = 12;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned DUTY_W   = 14;
    localparam int unsigned UPPER_W  = 6;
    localparam int unsigned LOWER_W  = 8;
    localparam int unsigned SEL_W    = 2;
    localparam int unsigned PRE_W    = 3;
    localparam int unsigned PERIOD_W = 18;

    // Printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'hd0;
    localparam logic [7:0] IDX_UPPER   = 8'hd1;
    localparam logic [7:0] IDX_LOWER   = 8'hd2;
    localparam logic [7:0] IDX_STATUS  = 8'hd3;

    localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_UPPER   = {2'h0, IDX_UPPER, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_LOWER   = {2'h0, IDX_LOWER, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = {2'h0, IDX_STATUS, 2'h0};

    // Field positions
    localparam int unsigned SEL_LSB     = 0;
    localparam int unsigned UPPER_LSB   = 0;
    localparam int unsigned LOWER_LSB   = 0;
    localparam int unsigned ST_CNT_LSB  = 0;
    localparam int unsigned ST_OUT_BIT  = 16;
    localparam int unsigned ST_SEL_LSB  = 18;

    // Clock-select codes
    localparam logic [SEL_W-1:0] SEL_DIV2  = 2'h0;
    localparam logic [SEL_W-1:0] SEL_DIV4  = 2'h1;
    localparam logic [SEL_W-1:0] SEL_DIV8  = 2'h2;
    localparam logic [SEL_W-1:0] SEL_DIV16 = 2'h3;

    // Reset values
    localparam logic [SEL_W-1:0]   CONTROL_RST = 2'h0;
    localparam logic [UPPER_W-1:0] UPPER_RST   = 6'h00;
    localparam logic [LOWER_W-1:0] LOWER_RST   = 8'h00;
    localparam logic [DUTY_W-1:0]  DUTY_RST    = 14'h0000;
    localparam logic [DUTY_W-1:0]  COUNT_MAX   = 14'h3fff;
    localparam logic [PRE_W-1:0]   PRE_RST     = 3'h0;
    localparam logic [DATA_W-1:0]  RDATA_ZERO  = 32'h0000_0000;
    localparam logic [PERIOD_W-1:0] PERIOD_ONE = 18'h00001;
    localparam logic [PERIOD_W-1:0] PERIOD_BASE = 18'h04000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic [DATA_W-1:0] wdata;
    } pwm_apb_req_t;

    typedef struct packed {
        logic [SEL_W-1:0]  sel;
        logic              out;
        logic [DUTY_W-1:0] count;
    } pwm_status_t;

    // System clocks per modulation step: 1, 2, 4, 8
    function automatic logic [PRE_W-1:0] pwm_step_limit(input logic [SEL_W-1:0] sel);
        pwm_step_limit = PRE_W'((1 << sel) - 1);
    endfunction : pwm_step_limit

    // System clocks per waveform period: 16384 << sel
    function automatic logic [PERIOD_W-1:0] pwm_period(input logic [SEL_W-1:0] sel);
        pwm_period = PERIOD_BASE << sel;
    endfunction : pwm_period

endpackage : pwm_pkg

/* src/pwm_prescaler.sv */
// Prescaler: divided PWM input clock and one step pulse per half input clock
`timescale 1ns/10ps
`default_nettype none
module pwm_prescaler (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic [pwm_pkg::SEL_W-1:0]   clock_select,
    output logic                             step,
    output logic                             input_clk
);

    logic [pwm_pkg::PRE_W-1:0] div_cnt_reg;
    logic [pwm_pkg::PRE_W-1:0] div_cnt_next;
    logic                      step_reg;
    logic                      step_next;
    logic                      iclk_reg;
    logic                      iclk_next;

    always_comb begin
        div_cnt_next = div_cnt_reg + 3'h1;
        step_next    = 1'b0;
        iclk_next    = iclk_reg;
        // Compare with >= so a narrower select taken mid-count cannot stall
        if (div_cnt_reg >= pwm_pkg::pwm_step_limit(clock_select)) begin // RQ2
            div_cnt_next = pwm_pkg::PRE_RST;
            step_next    = 1'b1;
            iclk_next    = ~iclk_reg; // RQ5
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= pwm_pkg::PRE_RST;
            step_reg    <= 1'b0;
            iclk_reg    <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            step_reg    <= step_next;
            iclk_reg    <= iclk_next;
        end
    end

    assign step      = step_reg;
    assign input_clk = iclk_reg;

    logic [pwm_pkg::SEL_W-1:0] sel_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= pwm_pkg::CONTROL_RST;
        end else begin
            sel_q <= clock_select;
        end
    end

    property p_div16_step;
        @(posedge pclk) disable iff (!presetn || clock_select != sel_q)
        (step_reg && clock_select == pwm_pkg::SEL_DIV16)
            |=> !step_reg [*7] ##1 step_reg;
    endproperty
    a_div16_step: assert property (p_div16_step) else $error("div16 step spacing wrong"); // RQ2

    property p_div16_iclk;
        @(posedge pclk) disable iff (!presetn || clock_select != sel_q)
        ($rose(iclk_reg) && clock_select == pwm_pkg::SEL_DIV16)
            |-> iclk_reg [*8] ##1 !iclk_reg;
    endproperty
    a_div16_iclk: assert property (p_div16_iclk) else $error("div16 input clock wrong"); // RQ2

endmodule : pwm_prescaler
`default_nettype wire

/* src/pwm_top.sv */
// 14-bit PWM generator top: APB register file, period counter and waveform output
//
// Notes on behaviour
// RQ1: Duty is upper 6 bits from one register joined with lower 8 bits.
// RQ2: Divide-by-16 select clocks the PWM from system clock over sixteen.
// RQ3: Divide-by-16 gives 131072-clock period and 8-clock minimum width.
// RQ4: Divide-by-8 gives 65536-clock period and 4-clock minimum width.
// RQ5: Every output interval is timed by the prescaled input clock.
// RQ6: Select codes 0..3 divide by 2,4,8,16; divide-by-2 gives 16384 and 1.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module pwm_top (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [pwm_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [pwm_pkg::DATA_W-1:0]   pwdata,
    output logic      [pwm_pkg::DATA_W-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic                              pwm_out
);

    pwm_pkg::pwm_apb_req_t req;
    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

    // Bus slave state
    logic                          pready_reg;
    logic                          pready_next;
    logic [pwm_pkg::DATA_W-1:0]    prdata_reg;
    logic [pwm_pkg::DATA_W-1:0]    prdata_next;
    logic                          pslverr_reg;
    logic                          pslverr_next;

    // Register file state
    logic [pwm_pkg::SEL_W-1:0]     sel_reg;
    logic [pwm_pkg::SEL_W-1:0]     sel_next;
    logic [pwm_pkg::UPPER_W-1:0]   upper_reg;
    logic [pwm_pkg::UPPER_W-1:0]   upper_next;
    logic [pwm_pkg::LOWER_W-1:0]   lower_reg;
    logic [pwm_pkg::LOWER_W-1:0]   lower_next;

    // Waveform state
    logic [pwm_pkg::DUTY_W-1:0]    cnt_reg;
    logic [pwm_pkg::DUTY_W-1:0]    cnt_next;
    logic [pwm_pkg::DUTY_W-1:0]    duty_act_reg;
    logic [pwm_pkg::DUTY_W-1:0]    duty_act_next;
    logic                          out_reg;
    logic                          out_next;

    logic                          step;
    logic                          wrap;
    logic                          setup;
    logic                          commit;
    logic                          mapped;
    logic [pwm_pkg::DUTY_W-1:0]    duty_pend;
    pwm_pkg::pwm_status_t          status;

    function automatic logic pwm_is_mapped(input logic [pwm_pkg::ADDR_W-1:0] a);
        pwm_is_mapped = (a == pwm_pkg::ADDR_CONTROL) || (a == pwm_pkg::ADDR_UPPER) ||
                        (a == pwm_pkg::ADDR_LOWER) || (a == pwm_pkg::ADDR_STATUS);
    endfunction : pwm_is_mapped

    pwm_prescaler u_prescaler (
        .pclk         (pclk),
        .presetn      (presetn),
        .clock_select (sel_reg),
        .step         (step),
        .input_clk    ()
    );

    assign setup     = psel && !penable;
    assign commit    = psel && penable && pready_reg;
    assign mapped    = pwm_is_mapped(req.addr);
    assign duty_pend = {upper_reg, lower_reg}; // RQ1
    assign status    = '{sel: sel_reg, out: out_reg, count: cnt_reg};

    // Answer prepared in the setup cycle, so access phase completes at once
    always_comb begin
        pready_next  = setup;
        pslverr_next = 1'b0;
        prdata_next  = pwm_pkg::RDATA_ZERO;
        if (setup) begin
            pslverr_next = !mapped;
            if (!req.write && req.addr == pwm_pkg::ADDR_STATUS) begin
                prdata_next[pwm_pkg::ST_CNT_LSB +: pwm_pkg::DUTY_W] = status.count;
                prdata_next[pwm_pkg::ST_OUT_BIT]                    = status.out;
                prdata_next[pwm_pkg::ST_SEL_LSB +: pwm_pkg::SEL_W]  = status.sel;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= pwm_pkg::RDATA_ZERO;
        end else begin
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end
    end

    // Write-only registers; a write lands at the completing edge only
    always_comb begin
        sel_next   = sel_reg;
        upper_next = upper_reg;
        lower_next = lower_reg;
        if (commit && req.write) begin
            if (req.addr == pwm_pkg::ADDR_CONTROL) begin
                sel_next = req.wdata[pwm_pkg::SEL_LSB +: pwm_pkg::SEL_W]; // RQ6
            end
            if (req.addr == pwm_pkg::ADDR_UPPER) begin
                upper_next = req.wdata[pwm_pkg::UPPER_LSB +: pwm_pkg::UPPER_W]; // RQ1
            end
            if (req.addr == pwm_pkg::ADDR_LOWER) begin
                lower_next = req.wdata[pwm_pkg::LOWER_LSB +: pwm_pkg::LOWER_W]; // RQ1
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg   <= pwm_pkg::CONTROL_RST;
            upper_reg <= pwm_pkg::UPPER_RST;
            lower_reg <= pwm_pkg::LOWER_RST;
        end else begin
            sel_reg   <= sel_next;
            upper_reg <= upper_next;
            lower_reg <= lower_next;
        end
    end

    // Duty taken only at period end, so a split two-register update made between two successive wraps never glitches
    assign wrap = step && (cnt_reg == pwm_pkg::COUNT_MAX);

    always_comb begin
        cnt_next      = cnt_reg;
        duty_act_next = duty_act_reg;
        out_next      = out_reg;
        if (step) begin // RQ5
            cnt_next = cnt_reg + 14'h0001;
            if (wrap) begin
                duty_act_next = duty_pend; // RQ1
            end
            out_next = (cnt_next < duty_act_next); // RQ3 RQ4 RQ6
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg      <= pwm_pkg::DUTY_RST;
            duty_act_reg <= pwm_pkg::DUTY_RST;
            out_reg      <= 1'b0;
        end else begin
            cnt_reg      <= cnt_next;
            duty_act_reg <= duty_act_next;
            out_reg      <= out_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign pwm_out = out_reg;

    // Helper counters read only by the checks below
    logic [pwm_pkg::PERIOD_W-1:0] hold_reg;
    logic [pwm_pkg::PERIOD_W-1:0] since_wrap_reg;
    logic [pwm_pkg::SEL_W-1:0]    sel_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg       <= '0;
            since_wrap_reg <= '0;
            sel_q          <= pwm_pkg::CONTROL_RST;
        end else begin
            sel_q <= sel_reg;
            if (sel_reg != sel_q) begin
                hold_reg <= '0;
            end else if (hold_reg != '1) begin
                hold_reg <= hold_reg + pwm_pkg::PERIOD_ONE;
            end
            since_wrap_reg <= wrap ? '0 : since_wrap_reg + pwm_pkg::PERIOD_ONE;
        end
    end

    // Settled once the last wrap came after the latest select change: the
    // interval since then is made of whole steps at the new rate only
    logic settled;
    assign settled = hold_reg > since_wrap_reg;

    sequence s_write_done(logic [pwm_pkg::ADDR_W-1:0] a);
        psel && penable && pready_reg && pwrite && paddr == a;
    endsequence

    property p_upper_merge;
        @(posedge pclk) disable iff (!presetn)
        s_write_done(pwm_pkg::ADDR_UPPER)
            |=> duty_pend[pwm_pkg::DUTY_W-1 -: pwm_pkg::UPPER_W]
                == $past(pwdata[pwm_pkg::UPPER_W-1:0]);
    endproperty
    a_upper_merge: assert property (p_upper_merge) else $error("upper duty bits not merged"); // RQ1

    property p_lower_merge;
        @(posedge pclk) disable iff (!presetn)
        s_write_done(pwm_pkg::ADDR_LOWER)
            |=> duty_pend[pwm_pkg::LOWER_W-1:0] == $past(pwdata[pwm_pkg::LOWER_W-1:0]);
    endproperty
    a_lower_merge: assert property (p_lower_merge) else $error("lower duty bits not merged"); // RQ1

    property p_period16;
        @(posedge pclk) disable iff (!presetn)
        (wrap && settled && sel_reg == pwm_pkg::SEL_DIV16)
            |-> since_wrap_reg == 18'h1ffff;
    endproperty
    a_period16: assert property (p_period16) else $error("div16 period not 131072"); // RQ3

    property p_width16;
        @(posedge pclk) disable iff (!presetn || !settled)
        ($rose(out_reg) && sel_reg == pwm_pkg::SEL_DIV16 && duty_act_reg == 14'h0001)
            |-> out_reg [*8] ##1 !out_reg;
    endproperty
    a_width16: assert property (p_width16) else $error("div16 minimum width not 8"); // RQ3

    property p_period8;
        @(posedge pclk) disable iff (!presetn)
        (wrap && settled && sel_reg == pwm_pkg::SEL_DIV8)
            |-> since_wrap_reg == 18'h0ffff;
    endproperty
    a_period8: assert property (p_period8) else $error("div8 period not 65536"); // RQ4

    property p_width8;
        @(posedge pclk) disable iff (!presetn || !settled)
        ($rose(out_reg) && sel_reg == pwm_pkg::SEL_DIV8 && duty_act_reg == 14'h0001)
            |-> out_reg [*4] ##1 !out_reg;
    endproperty
    a_width8: assert property (p_width8) else $error("div8 minimum width not 4"); // RQ4

    property p_step_timed;
        @(posedge pclk) disable iff (!presetn)
        $changed(out_reg) |-> $past(step);
    endproperty
    a_step_timed: assert property (p_step_timed) else $error("output moved off a step"); // RQ5

    property p_period2;
        @(posedge pclk) disable iff (!presetn)
        (wrap && settled && sel_reg == pwm_pkg::SEL_DIV2)
            |-> since_wrap_reg == 18'h03fff;
    endproperty
    a_period2: assert property (p_period2) else $error("div2 period not 16384"); // RQ6

    property p_width2;
        @(posedge pclk) disable iff (!presetn || !settled)
        ($rose(out_reg) && sel_reg == pwm_pkg::SEL_DIV2 && duty_act_reg == 14'h0001)
            |-> ##1 !out_reg;
    endproperty
    a_width2: assert property (p_width2) else $error("div2 minimum width not 1"); // RQ6

    property p_sel_write;
        @(posedge pclk) disable iff (!presetn)
        s_write_done(pwm_pkg::ADDR_CONTROL)
            |=> sel_reg == $past(pwdata[pwm_pkg::SEL_W-1:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("clock select not stored"); // RQ6

endmodule : pwm_top
`default_nettype wire

/* tb/pwm_14bit_generator_test.sv */
// Self-checking bench for the PWM generator: APB register access and waveform timing
`timescale 1ns/10ps
`default_nettype none
module pwm_14bit_generator_test;
    logic                         pclk    = 1'b0;
    logic                         presetn = 1'b0;
    logic                         psel    = 1'b0;
    logic                         penable = 1'b0;
    logic                         pwrite  = 1'b0;
    logic [pwm_pkg::ADDR_W-1:0]   paddr   = 12'h000;
    logic [pwm_pkg::DATA_W-1:0]   pwdata  = 32'h0000_0000;
    logic [pwm_pkg::DATA_W-1:0]   prdata;
    logic                         pready;
    logic                         pslverr;
    logic                         pwm_out;
    logic [15:0]                  rise_count;
    logic [31:0]                  high_cycles;
    logic [31:0]                  period_cycles;
    int                           fails     = 0;
    int                           tests_run = 0;

    always #2 pclk = ~pclk;

    pwm_top i_dut (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .pwm_out (pwm_out)
    );

    pwm_load_model i_load (
        .pclk          (pclk),
        .presetn       (presetn),
        .pwm_out       (pwm_out),
        .rise_count    (rise_count),
        .high_cycles   (high_cycles),
        .period_cycles (period_cycles)
    );

    task automatic complete_run();
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // Request held until pready is sampled high at a rising edge; answer taken there
    task automatic apb(input logic wr, input logic [pwm_pkg::ADDR_W-1:0] a,
                       input logic [31:0] d, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        er = pslverr;
        if (n >= 64) fails++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [pwm_pkg::ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr_reg

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask : chk

    task automatic wait_rises(input int k);
        int target;
        int n;
        target = rise_count + k;
        n = 0;
        while (rise_count < target && n < 70000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 70000) fails++;
    endtask : wait_rises

    initial begin
        // Two div2 periods plus two div4 periods dominate: about 99k clocks
        #(104000 * 4);
        fails++;
        complete_run();
    end

    initial begin
        logic [31:0] r;
        logic [31:0] s1;
        logic [31:0] s2;
        logic        e;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, pwm_pkg::ADDR_STATUS, 32'h0, r, e);
        chk("reset out and select", 32'h0, r & 32'h000d_0000);
        apb(1'b0, 12'h000, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        apb(1'b0, pwm_pkg::ADDR_CONTROL, 32'h0, r, e);
        chk("control read data", 32'h0, r);
        chk("control read error", 32'h0, {31'h0, e});
        // Reserved control bits set on purpose; only the select field may stick
        for (int sel = 0; sel < 4; sel++) begin
            wr_reg(pwm_pkg::ADDR_CONTROL, 32'hffff_fffc | sel);
            repeat (16) @(posedge pclk);
            apb(1'b0, pwm_pkg::ADDR_STATUS, 32'h0, s1, e);
            repeat (61) @(posedge pclk);
            apb(1'b0, pwm_pkg::ADDR_STATUS, 32'h0, s2, e);
            chk("select field", sel, (s2 >> 18) & 32'h3);
            chk("steps in 64 clocks", 32'd64 >> sel, (s2 - s1) & 32'h3fff);
        end
        chk("no pulse at zero duty", 32'h0, {16'h0, rise_count});
        wr_reg(pwm_pkg::ADDR_CONTROL, 32'h0);
        wr_reg(pwm_pkg::ADDR_UPPER, 32'h0000_0001);
        wr_reg(pwm_pkg::ADDR_LOWER, 32'h0000_0005);
        wait_rises(2);
        chk("divide-by-2 period", 32'd16384, period_cycles);
        chk("joined duty high time", 32'd261, high_cycles);
        wr_reg(pwm_pkg::ADDR_UPPER, 32'h0000_0000);
        wr_reg(pwm_pkg::ADDR_LOWER, 32'h0000_0001);
        wr_reg(pwm_pkg::ADDR_CONTROL, 32'h0000_0001);
        wait_rises(2);
        chk("divide-by-4 period", 32'd32768, period_cycles);
        chk("divide-by-4 minimum width", 32'd2, high_cycles);
        complete_run();
    end
endmodule : pwm_14bit_generator_test
`default_nettype wire

/* tb/pwm_load_model.sv */
// Passive load on the PWM pin: measures high time and rise-to-rise period
`timescale 1ns/10ps
`default_nettype none
module pwm_load_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pwm_out,
    output logic      [15:0] rise_count,
    output logic      [31:0] high_cycles,
    output logic      [31:0] period_cycles
);
    logic        last_reg;
    logic [31:0] since_rise_reg;

    // First period after reset is partial; callers skip it by counting rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_reg       <= 1'b0;
            since_rise_reg <= 32'h0000_0000;
            rise_count     <= 16'h0000;
            high_cycles    <= 32'h0000_0000;
            period_cycles  <= 32'h0000_0000;
        end else begin
            last_reg       <= pwm_out;
            since_rise_reg <= since_rise_reg + 32'h0000_0001;
            if (pwm_out && !last_reg) begin
                rise_count     <= rise_count + 16'h0001;
                period_cycles  <= since_rise_reg;
                since_rise_reg <= 32'h0000_0001;
            end
            if (!pwm_out && last_reg) begin
                high_cycles <= since_rise_reg;
            end
        end
    end
endmodule : pwm_load_model
`default_nettype wire
